// ==== hdl/isi_host_if.sv ====
// isi_host_if: isa slave front end - dma qualify, address latch, bus strap,
// channel-ready wait states, 16-bit i/o select decode, i/o read drive
// assumes: bus strobes synchronous to mclk_i; memory controller outside
`timescale 1ns/10ps
// Operation
// - address-enable high marks dma; no i/o read or write is answered
// - address-enable never gates display memory refresh
// - upper address latch transparent while strobe high, holds at fall
// - channel-ready stays high through i/o reads and bios reads
// - memory read: ready low at strobe fall, high when data ready, float
// - memory write: ready high if buffer has room, else low until free
// - after stalled write, ready high until strobe rises, then float
// - 16-bit i/o select pulled low only for 16-bit capable addresses
// - i/o read strobe with address in range puts register data on bus
module isi_host_if #(
   parameter int unsigned LA_W = isi_pkg::LA_W
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic aen_i,
   input wire logic bale_i,
   input wire logic [LA_W-1:0] la_i,
   input wire logic [15:0] sa_i,
   input wire logic bus_type_select_n_i,
   input wire logic local_bus_type_bit0_i,
   input wire logic local_bus_type_bit1_i,
   input wire logic iord_n_i,
   input wire logic iowr_n_i,
   input wire logic smemr_n_i,
   input wire logic smemw_n_i,
   input wire logic vmem_sel_i,
   input wire logic bios_sel_i,
   input wire logic io_range_i,
   input wire logic rd_data_ready_i,
   input wire logic wbuf_full_i,
   input wire logic [15:0] reg_rdata_i,
   input wire logic refresh_req_i,
   output logic [LA_W-1:0] la_latched_o,
   output isi_pkg::isi_bus_t bus_type_o,
   output logic io_rd_o,
   output logic io_wr_o,
   output logic wbuf_push_o,
   output logic refresh_go_o,
   output logic iochrdy_o,
   output logic iochrdy_oe_n_o,
   output logic iocs16_o,
   output logic iocs16_oe_n_o,
   output logic [15:0] sd_o,
   output logic sd_oe_n_o
);
   typedef enum logic [1:0] {
      RDY_IDLE,
      RDY_WAIT,
      RDY_HIGH
   } isi_rdy_t;

   isi_rdy_t rdy_q;
   logic strap_done_q;
   isi_pkg::isi_bus_t bus_q;
   logic smemr_n_q;
   logic smemw_n_q;
   logic iord_n_q;
   logic iowr_n_q;
   logic [15:0] sd_q;
   logic sd_oe_n_q;
   logic iocs_hit;
   logic io_ok;
   logic mr_fall;
   logic mw_fall;
   logic mem_rise;

   isi_addr_latch #(
      .W(LA_W)
   ) u_latch (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .strobe_i(bale_i),
      .addr_i(la_i),
      .addr_o(la_latched_o)
   );

   // strap caught once after reset release, not under reset
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         strap_done_q <= 1'b0;
         bus_q <= isi_pkg::ISI_BUS_ISA;
      end else if (ce_i && !strap_done_q) begin
         strap_done_q <= 1'b1;
         if (bus_type_select_n_i) begin
            bus_q <= isi_pkg::ISI_BUS_ISA;
         end else begin
            unique case ({local_bus_type_bit1_i, local_bus_type_bit0_i})
               2'b00: bus_q <= isi_pkg::ISI_BUS_PI;
               2'b01: bus_q <= isi_pkg::ISI_BUS_LB_SX;
               2'b10: bus_q <= isi_pkg::ISI_BUS_LB_DX;
               2'b11: bus_q <= isi_pkg::ISI_BUS_LB_486;
            endcase
         end
      end
   end
   assign bus_type_o = bus_q;

   // strobe history for edge detection
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         smemr_n_q <= 1'b1;
         smemw_n_q <= 1'b1;
         iord_n_q <= 1'b1;
         iowr_n_q <= 1'b1;
      end else if (ce_i) begin
         smemr_n_q <= smemr_n_i;
         smemw_n_q <= smemw_n_i;
         iord_n_q <= iord_n_i;
         iowr_n_q <= iowr_n_i;
      end
   end

   // bios reads never stall, so they skip the ready sequencer
   assign mr_fall = smemr_n_q && !smemr_n_i && vmem_sel_i
      && !bios_sel_i;
   assign mw_fall = smemw_n_q && !smemw_n_i && vmem_sel_i;
   assign mem_rise = smemr_n_i && smemw_n_i;

   // i/o cycles only when not dma
   assign io_ok = !aen_i && io_range_i;
   assign io_rd_o = ce_i && io_ok && iord_n_q && !iord_n_i;
   assign io_wr_o = ce_i && io_ok && iowr_n_q && !iowr_n_i;
   // a stalled write is pushed on the cycle its buffer slot frees
   assign wbuf_push_o = ce_i && !wbuf_full_i && (mw_fall
      || (rdy_q == RDY_WAIT && smemr_n_i && !smemw_n_i));
   // refresh is independent of address-enable by design
   assign refresh_go_o = refresh_req_i;

   // channel-ready sequencer for display memory cycles
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdy_q <= RDY_IDLE;
      end else if (ce_i) begin
         unique case (rdy_q)
            RDY_IDLE: begin
               if (mr_fall) begin
                  rdy_q <= RDY_WAIT;
               end else if (mw_fall) begin
                  rdy_q <= wbuf_full_i ? RDY_WAIT : RDY_HIGH;
               end
            end
            RDY_WAIT: begin
               if (mem_rise) begin
                  rdy_q <= RDY_IDLE;
               end else if (!smemr_n_i ? rd_data_ready_i : !wbuf_full_i) begin
                  rdy_q <= RDY_HIGH;
               end
            end
            RDY_HIGH: begin
               if (mem_rise) begin
                  rdy_q <= RDY_IDLE;
               end
            end
         endcase
      end
   end

   // low drive starts on the falling-edge cycle itself, no late stall
   always_comb begin
      iochrdy_o = 1'b1;
      iochrdy_oe_n_o = 1'b1;
      unique case (rdy_q)
         RDY_IDLE: begin
            if (mr_fall) begin
               iochrdy_o = 1'b0;
               iochrdy_oe_n_o = 1'b0;
            end else if (mw_fall) begin
               iochrdy_o = !wbuf_full_i;
               iochrdy_oe_n_o = 1'b0;
            end
         end
         RDY_WAIT: begin
            iochrdy_o = 1'b0;
            iochrdy_oe_n_o = 1'b0;
         end
         RDY_HIGH: begin
            iochrdy_o = 1'b1;
            iochrdy_oe_n_o = 1'b0;
         end
      endcase
   end

   // 16-bit select decode; output pin only ever driven low
   always_comb begin
      unique case (sa_i)
         isi_pkg::IO_SEQ_IDX, isi_pkg::IO_SEQ_DAT,
         isi_pkg::IO_GFX_IDX, isi_pkg::IO_GFX_DAT,
         isi_pkg::IO_CRT_IDX_M, isi_pkg::IO_CRT_DAT_M,
         isi_pkg::IO_CRT_IDX_C, isi_pkg::IO_CRT_DAT_C,
         isi_pkg::IO_STAT1_M, isi_pkg::IO_STAT1_C: iocs_hit = 1'b1;
         default: iocs_hit = 1'b0;
      endcase
   end
   assign iocs16_o = 1'b0;
   assign iocs16_oe_n_o = !(iocs_hit && !aen_i);

   // register data onto the bus for a qualified i/o read
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sd_q <= 16'h0000;
         sd_oe_n_q <= 1'b1;
      end else if (ce_i) begin
         sd_oe_n_q <= !(io_ok && !iord_n_i);
         if (io_ok && !iord_n_i) begin
            sd_q <= reg_rdata_i;
         end
      end
   end
   assign sd_o = sd_q;
   assign sd_oe_n_o = sd_oe_n_q;

   sequence s_mr_fall;
      ce_i && rdy_q == RDY_IDLE && mr_fall;
   endsequence
   sequence s_wait_free;
      ce_i && rdy_q == RDY_WAIT && smemr_n_i && !smemw_n_i && !wbuf_full_i;
   endsequence

   AST_DMA_NO_IO: assert property (@(posedge mclk_i) disable iff (rst_i)
      aen_i |-> !io_rd_o && !io_wr_o)
      else $error("i/o cycle answered during dma");
   AST_REFRESH_PASS: assert property (@(posedge mclk_i) disable iff (rst_i)
      refresh_req_i |-> refresh_go_o)
      else $error("refresh blocked");
   AST_STRAP_ISA: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && !strap_done_q && bus_type_select_n_i)
      |=> bus_type_o == isi_pkg::ISI_BUS_ISA)
      else $error("isa strap not honoured");
   AST_IO_READY_HIGH: assert property (@(posedge mclk_i) disable iff (rst_i)
      (rdy_q == RDY_IDLE && !mr_fall && !mw_fall) |-> iochrdy_o)
      else $error("ready low outside display memory cycle");
   AST_MR_STALL: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_mr_fall |-> !iochrdy_o && !iochrdy_oe_n_o
      ##1 (!iochrdy_o || mem_rise))
      else $error("ready not low after memory read fall");
   AST_MW_ROOM: assert property (@(posedge mclk_i) disable iff (rst_i)
      (rdy_q == RDY_IDLE && mw_fall && !wbuf_full_i)
      |-> iochrdy_o && !iochrdy_oe_n_o)
      else $error("ready low although write buffer has room");
   AST_MW_FREE: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_wait_free |=> (iochrdy_o && !iochrdy_oe_n_o)
      || $past(mem_rise))
      else $error("ready not raised when buffer frees");
   AST_FLOAT_AFTER: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && rdy_q == RDY_HIGH && mem_rise) |=> rdy_q == RDY_IDLE)
      else $error("ready not released after strobe rise");
   AST_CS16_DMA: assert property (@(posedge mclk_i) disable iff (rst_i)
      aen_i |-> iocs16_oe_n_o)
      else $error("16-bit select driven during dma");
   AST_CS16_HIT: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!aen_i && sa_i == isi_pkg::IO_SEQ_IDX) |-> !iocs16_oe_n_o)
      else $error("16-bit select missing for sequencer index");
   AST_IORD_DATA: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && io_ok && !iord_n_i) |=> !sd_oe_n_o
      && sd_o == $past(reg_rdata_i))
      else $error("register data not driven on i/o read");
endmodule

// ==== hdl/isi_pkg.sv ====
// isi_pkg: constants for the isa slave host interface front end
// assumes: single 100 MHz clock, all bus inputs already synchronous
package isi_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned LA_W = 7;
   localparam int unsigned LA_LSB = 17;
   localparam logic [LA_W-1:0] LA_RST = 7'h00;
   // bus variants, from type bits {bit1, bit0} with select low
   typedef enum logic [2:0] {
      ISI_BUS_ISA,
      ISI_BUS_PI,
      ISI_BUS_LB_SX,
      ISI_BUS_LB_DX,
      ISI_BUS_LB_486
   } isi_bus_t;
   // 16-bit capable i/o addresses
   localparam logic [15:0] IO_SEQ_IDX = 16'h03C4;
   localparam logic [15:0] IO_SEQ_DAT = 16'h03C5;
   localparam logic [15:0] IO_GFX_IDX = 16'h03CE;
   localparam logic [15:0] IO_GFX_DAT = 16'h03CF;
   localparam logic [15:0] IO_CRT_IDX_M = 16'h03B4;
   localparam logic [15:0] IO_CRT_DAT_M = 16'h03B5;
   localparam logic [15:0] IO_CRT_IDX_C = 16'h03D4;
   localparam logic [15:0] IO_CRT_DAT_C = 16'h03D5;
   localparam logic [15:0] IO_STAT1_M = 16'h03BA;
   localparam logic [15:0] IO_STAT1_C = 16'h03DA;
endpackage

// ==== hdl/isi_addr_latch.sv ====
// isi_addr_latch: transparent-while-high latch for upper address lines
// assumes: strobe sampled on mclk_i; hold value taken at the falling edge
`timescale 1ns/10ps
module isi_addr_latch #(
   parameter int unsigned W = 7
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic strobe_i,
   input wire logic [W-1:0] addr_i,
   output logic [W-1:0] addr_o
);
   logic [W-1:0] hold_q;

   // flop copy follows the lines while high; freezes when strobe falls
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hold_q <= '0;
      end else if (ce_i && strobe_i) begin
         hold_q <= addr_i;
      end
   end

   // pass-through while high keeps the latch transparent, not a cycle late
   assign addr_o = strobe_i ? addr_i : hold_q;

   AST_LATCH_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && $fell(strobe_i)) |-> addr_o == $past(addr_i))
      else $error("latched address differs from value at strobe fall");
endmodule

// ==== tb/isi_hm.sv ====
// isi_hm: host bus master model, drives address, strobes and straps
// assumes: bench steps it by task; changes land just after posedge
`timescale 1ns/10ps
module isi_hm (
   input wire logic mclk_i,
   output logic aen_o,
   output logic bale_o,
   output logic [6:0] la_o,
   output logic [15:0] sa_o,
   output logic [3:0] strb_n_o,
   output logic sel_n_o,
   output logic bit0_o,
   output logic bit1_o
);
   logic [1:0] type_q;
   // isa mode ties bit0 high and wires bit1 to the memory write strobe
   assign bit0_o = sel_n_o ? 1'b1 : type_q[0];
   assign bit1_o = sel_n_o ? strb_n_o[0] : type_q[1];
   initial begin
      aen_o = 1'b0;
      bale_o = 1'b0;
      la_o = 7'h00;
      sa_o = 16'h0000;
      strb_n_o = 4'hF;
      sel_n_o = 1'b1;
      type_q = 2'h0;
   end
   // strobes {iord, iowr, smemr, smemw}, all active low
   task drive(input logic a, input logic b, input logic [6:0] l,
      input logic [15:0] s, input logic [3:0] st);
      @(posedge mclk_i);
      aen_o <= a;
      bale_o <= b;
      la_o <= l;
      sa_o <= s;
      strb_n_o <= st;
   endtask
   task strap(input logic sel_n, input logic [1:0] t);
      @(posedge mclk_i);
      sel_n_o <= sel_n;
      type_q <= t;
   endtask
endmodule

// ==== tb/tb_top.sv ====
// tb_top: directed bench for the isa slave front end
// assumes: host model drives the bus side, bench the memory side
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic io_range_i = 1'b0;
   logic rd_data_ready_i = 1'b0;
   logic wbuf_full_i = 1'b0;
   logic [15:0] reg_rdata_i = 16'h0000;
   logic refresh_req_i = 1'b0;
   logic bios_sel_i = 1'b0;
   logic aen, bale, sel_n, bit0, bit1;
   logic [6:0] la, la_latched_o;
   logic [15:0] sa, sd_o;
   logic [3:0] st;
   isi_pkg::isi_bus_t bus_type_o;
   logic io_rd_o, io_wr_o, wbuf_push_o, refresh_go_o, sd_oe_n_o;
   logic iochrdy_o, iochrdy_oe_n_o, iocs16_o, iocs16_oe_n_o;
   int errors = 0;
   int total_checks = 0;
   // both pins carry board pull-ups, so a released pin reads high
   wire rdy_w = iochrdy_oe_n_o ? 1'b1 : iochrdy_o;
   wire cs16_w = iocs16_oe_n_o ? 1'b1 : iocs16_o;
   logic [15:0] cs_tab [12] = '{16'h03C4, 16'h03C5, 16'h03CE, 16'h03CF,
      16'h03B4, 16'h03B5, 16'h03D4, 16'h03D5, 16'h03BA, 16'h03DA,
      16'h03C6, 16'h02C4};
   initial forever #5 mclk_i = ~mclk_i;
   isi_hm isi_hm_i (.mclk_i(mclk_i), .aen_o(aen), .bale_o(bale),
      .la_o(la), .sa_o(sa), .strb_n_o(st), .sel_n_o(sel_n),
      .bit0_o(bit0), .bit1_o(bit1));
   isi_host_if isi_host_if_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
      .aen_i(aen), .bale_i(bale), .la_i(la), .sa_i(sa),
      .bus_type_select_n_i(sel_n), .local_bus_type_bit0_i(bit0),
      .local_bus_type_bit1_i(bit1), .iord_n_i(st[3]), .iowr_n_i(st[2]),
      .smemr_n_i(st[1]), .smemw_n_i(st[0]), .vmem_sel_i(1'b1),
      .bios_sel_i(bios_sel_i), .io_range_i(io_range_i),
      .rd_data_ready_i(rd_data_ready_i), .wbuf_full_i(wbuf_full_i),
      .reg_rdata_i(reg_rdata_i), .refresh_req_i(refresh_req_i),
      .la_latched_o(la_latched_o), .bus_type_o(bus_type_o),
      .io_rd_o(io_rd_o), .io_wr_o(io_wr_o), .wbuf_push_o(wbuf_push_o),
      .refresh_go_o(refresh_go_o), .iochrdy_o(iochrdy_o),
      .iochrdy_oe_n_o(iochrdy_oe_n_o), .iocs16_o(iocs16_o),
      .iocs16_oe_n_o(iocs16_oe_n_o), .sd_o(sd_o), .sd_oe_n_o(sd_oe_n_o));
   task final_report;
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wait_rdy;
      int n;
      for (n = 0; n < 8 && rdy_w !== 1'b1; n++) @(negedge mclk_i);
      if (n == 8) begin
         errors++;
         final_report;
      end
   endtask
   task t_strap;
      for (int i = 4; i >= 0; i--) begin
         isi_hm_i.strap(i == 0, 2'(i - 1));
         rst_i <= 1'b1;
         repeat (6) @(posedge mclk_i);
         rst_i <= 1'b0;
         repeat (2) @(negedge mclk_i);
         `CHK(bus_type_o, isi_pkg::isi_bus_t'(i))
      end
      `CHK({iochrdy_oe_n_o, sd_oe_n_o, la_latched_o}, 9'h180)
   endtask
   task t_latch;
      isi_hm_i.drive(0, 1, 7'h55, 0, 4'hF);
      @(negedge mclk_i) `CHK(la_latched_o, 7'h55)
      isi_hm_i.drive(0, 1, 7'h2A, 0, 4'hF);
      @(negedge mclk_i) `CHK(la_latched_o, 7'h2A)
      isi_hm_i.drive(0, 0, 7'h2A, 0, 4'hF);
      isi_hm_i.drive(0, 0, 7'h11, 0, 4'hF);
      repeat (2) @(negedge mclk_i);
      `CHK(la_latched_o, 7'h2A)
   endtask
   task t_cs16;
      for (int i = 0; i < 12; i++) begin
         isi_hm_i.drive(0, 0, 0, cs_tab[i], 4'hF);
         @(negedge mclk_i) `CHK(cs16_w, i > 9)
      end
      isi_hm_i.drive(1, 0, 0, 16'h03C4, 4'hF);
      @(negedge mclk_i) `CHK(cs16_w, 1'b1)
   endtask
   task t_io(input logic a);
      isi_hm_i.drive(a, 0, 0, 16'h03C4, 4'h7);
      io_range_i <= 1'b1;
      reg_rdata_i <= 16'hA5C3;
      @(negedge mclk_i);
      `CHK({io_rd_o, rdy_w}, {!a, 1'b1})
      @(negedge mclk_i) `CHK(sd_oe_n_o, a)
      if (!a) `CHK(sd_o, 16'hA5C3)
      isi_hm_i.drive(a, 0, 0, 16'h03C4, 4'hF);
      isi_hm_i.drive(a, 0, 0, 16'h03C4, 4'hB);
      @(negedge mclk_i) `CHK(io_wr_o, !a)
      isi_hm_i.drive(0, 0, 0, 16'h03C4, 4'hF);
      repeat (2) @(negedge mclk_i);
      `CHK(sd_oe_n_o, 1'b1)
   endtask
   task t_mrd;
      isi_hm_i.drive(1, 0, 0, 0, 4'hD);
      refresh_req_i <= 1'b1;
      @(negedge mclk_i);
      `CHK({rdy_w, refresh_go_o}, 2'b01)
      repeat (3) @(negedge mclk_i);
      `CHK({rdy_w, iochrdy_oe_n_o}, 2'b00)
      @(posedge mclk_i) rd_data_ready_i <= 1'b1;
      wait_rdy;
      `CHK(iochrdy_oe_n_o, 1'b0)
      isi_hm_i.drive(0, 0, 0, 0, 4'hF);
      rd_data_ready_i <= 1'b0;
      refresh_req_i <= 1'b0;
      repeat (2) @(negedge mclk_i);
      `CHK({iochrdy_oe_n_o, refresh_go_o}, 2'b10)
   endtask
   // a bios read with the memory strobe low must never stall the host
   task t_bios;
      isi_hm_i.drive(0, 0, 0, 0, 4'hD);
      bios_sel_i <= 1'b1;
      @(negedge mclk_i) `CHK({rdy_w, iochrdy_oe_n_o}, 2'b11)
      @(negedge mclk_i) `CHK({rdy_w, iochrdy_oe_n_o}, 2'b11)
      isi_hm_i.drive(0, 0, 0, 0, 4'hF);
      bios_sel_i <= 1'b0;
   endtask
   task t_mwr(input logic full);
      isi_hm_i.drive(0, 0, 0, 0, 4'hE);
      wbuf_full_i <= full;
      @(negedge mclk_i) `CHK({rdy_w, wbuf_push_o}, {!full, !full})
      repeat (3) @(negedge mclk_i);
      `CHK({rdy_w, iochrdy_oe_n_o}, {!full, 1'b0})
      @(posedge mclk_i) wbuf_full_i <= 1'b0;
      @(negedge mclk_i) `CHK({rdy_w, wbuf_push_o}, {!full, full})
      wait_rdy;
      `CHK(iochrdy_oe_n_o, 1'b0)
      isi_hm_i.drive(0, 0, 0, 0, 4'hF);
      repeat (2) @(negedge mclk_i);
      `CHK(iochrdy_oe_n_o, 1'b1)
   endtask
   initial begin
      t_strap;
      t_latch;
      t_cs16;
      t_io(1'b0);
      t_io(1'b1);
      t_mrd;
      t_bios;
      t_mwr(1'b0);
      t_mwr(1'b1);
      final_report;
   end
endmodule
